// ===== rtl/hsd_ctrl.sv
// mode, protection and register core of the high-side gate driver
//
// Functional notes
// - short compare ignored until main gate enhanced
// - no timer cap: fast gate off, fault
// - overcurrent starts delay timer charging
// - timer trip: gate off, fault, retry
// - retry: 32 discharge/charge cycles, then restore
// - later retry intervals below ten microseconds
// - short gone early: gate stays, timer cleared
// - latch-off: gate off for good, fault
// - latch cleared by command, request, enable, supply
// - self-test edge injects simulated short
// - supply low: everything off
// - enable low: shutdown, gates off
// - enable with request low 500us: low power
// - enable and request together: active
// - low power: bypass on, wake released
// - load wakeup: bypass off, main on, wake
// - active only after request driven high
// - low power undervoltage: bypass off, fault
// - low power short: wakeup then protection
// - active: main follows command, wake asserted
// - active undervoltage or short: gate off, fault
// - wakeup ignored until bypass gate enhanced
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module hsd_ctrl #(
   parameter int unsigned LPM_HOLD = hsd_pkg::LPM_HOLD_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        supply_por_ok_i,
   input  wire logic        enable_undervoltage_input_i,
   input  wire logic        low_power_request_n_i,
   input  wire logic        main_gate_command_i,
   input  wire logic        short_detect_selftest_i,
   input  wire logic        short_circuit_compare_i,
   input  wire logic        load_wakeup_compare_i,
   input  wire logic        main_gate_enhanced_level_i,
   input  wire logic        bypass_gate_enhanced_level_i,
   input  wire logic        charge_pump_uv_level_i,
   input  wire logic        input_uv_falling_level_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             main_gate_pullup_o,
   output logic             main_gate_pulldown_o,
   output logic             bypass_gate_o,
   output logic             wake_n_o,
   output logic             fault_flag_n_o,
   output logic             charge_pump_en_o
);
   import hsd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisation
   hsd_pins_s  raw, pin;
   logic [$bits(hsd_pins_s)-1:0] pin_vec;

   assign raw = '{
      por_ok:                supply_por_ok_i,
      en_ok:                 enable_undervoltage_input_i,
      low_power_request_n:   low_power_request_n_i,
      main_gate_command:     main_gate_command_i,
      short_detect_selftest: short_detect_selftest_i,
      short_circuit_compare: short_circuit_compare_i,
      load_wakeup_compare:   load_wakeup_compare_i,
      main_gate_enhanced:    main_gate_enhanced_level_i,
      bypass_gate_enhanced:  bypass_gate_enhanced_level_i,
      charge_pump_uv:        charge_pump_uv_level_i,
      input_uv:              input_uv_falling_level_i
   };

   hsd_sync #(
      .W       ($bits(hsd_pins_s))
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (raw),
      .sync_o  (pin_vec)
   );
   assign pin = hsd_pins_s'(pin_vec);

   ////////////////////////////////////////////////////////////////////////////
   // register bus slave
   logic             wait_q, wait_d;
   logic [31:0]      rdata_q, rdata_d;
   logic [1:0]       ctrl_q, ctrl_d;
   logic [TMR_W-1:0] trip_q, trip_d;
   logic [TMR_W-1:0] low_q, low_d;
   logic             take, do_wr;
   logic [31:0]      stat_word;
   logic [31:0]      bmask;
   hsd_mode_e        md_q, md_d;
   logic             sc_fault, sc_latched, uv, inject_q, inject_d;
   hsd_gates_s       out_q, out_d;

   // one wait cycle per access; readdata is latched in that cycle
   assign take  = (avs_read_i || avs_write_i) && wait_q;
   assign do_wr = avs_write_i && !wait_q;
   assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   // fields above the latch bit read as zero
   assign stat_word = {22'h000000, sc_latched, uv, inject_q, sc_fault,
                       out_q.bypass_gate, out_q.main_gate_pullup, 1'b0,
                       md_q};

   always_comb begin
      wait_d  = 1'b1;
      rdata_d = rdata_q;
      ctrl_d  = ctrl_q;
      trip_d  = trip_q;
      low_d   = low_q;
      if (take) begin
         wait_d = 1'b0;
         if (avs_read_i) begin
            case (avs_address_i)
               ADDR_CTRL: rdata_d = {30'h00000000, ctrl_q};
               ADDR_TRIP: rdata_d = {8'h00, trip_q};
               ADDR_LOW:  rdata_d = {8'h00, low_q};
               ADDR_STAT: rdata_d = stat_word;
               default:   rdata_d = 32'h00000000;
            endcase
         end
      end
      // unmapped and status writes are dropped
      if (do_wr) begin
         case (avs_address_i)
            ADDR_CTRL: ctrl_d = (ctrl_q & ~bmask[1:0]) | (avs_writedata_i[1:0] & bmask[1:0]);
            ADDR_TRIP: trip_d = (trip_q & ~bmask[23:0]) | (avs_writedata_i[23:0] & bmask[23:0]);
            ADDR_LOW:  low_d  = (low_q & ~bmask[23:0]) | (avs_writedata_i[23:0] & bmask[23:0]);
            default:   ctrl_d = ctrl_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
         ctrl_q  <= CTRL_RST;
         trip_q  <= TRIP_RST;
         low_q   <= LOW_RST;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         ctrl_q  <= ctrl_d;
         trip_q  <= trip_d;
         low_q   <= low_d;
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = wait_q;

   ////////////////////////////////////////////////////////////////////////////
   // edges, latch clear and short detection
   logic        cmd_d1_q, lpm_d1_q, test_d1_q;
   logic        cmd_d1_d, lpm_d1_d, test_d1_d;
   logic        latch_clr, test_rise, oc, prot_on;
   logic [12:0] hold_q, hold_d;

   // delayed copies reset low, the idle level, so no false edge
   always_comb begin
      cmd_d1_d  = pin.main_gate_command;
      lpm_d1_d  = pin.low_power_request_n;
      test_d1_d = pin.short_detect_selftest;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmd_d1_q  <= 1'b0;
         lpm_d1_q  <= 1'b0;
         test_d1_q <= 1'b0;
      end else begin
         cmd_d1_q  <= cmd_d1_d;
         lpm_d1_q  <= lpm_d1_d;
         test_d1_q <= test_d1_d;
      end
   end

   // level clears keep the timer idle while off
   assign latch_clr = (cmd_d1_q && !pin.main_gate_command) ||
                      (lpm_d1_q && !pin.low_power_request_n) ||
                      !pin.en_ok || !pin.por_ok;
   assign test_rise = pin.short_detect_selftest && !test_d1_q;
   assign prot_on   = (md_q == MD_ACTIVE) || (md_q == MD_WAKEUP);
   // blanking while the main gate charges avoids tripping on inrush
   assign oc = out_q.main_gate_pullup && pin.main_gate_enhanced &&
               (pin.short_circuit_compare || inject_q);
   assign uv = pin.input_uv || pin.charge_pump_uv;

   hsd_fault_timer u_tmr (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .clear_i     (latch_clr),
      .oc_i        (oc),
      .nocap_i     (ctrl_q[CTRL_NOCAP_BIT]),
      .latch_off_i (ctrl_q[CTRL_LATCH_BIT]),
      .trip_lvl_i  (trip_q),
      .low_lvl_i   (low_q),
      .fault_o     (sc_fault),
      .latched_o   (sc_latched)
   );

   // injected short holds until the protection answers; a new edge wins
   always_comb begin
      inject_d = inject_q;
      if (sc_fault || latch_clr || !prot_on) begin
         inject_d = 1'b0;
      end
      if (test_rise && prot_on) begin
         inject_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         inject_q <= 1'b0;
      end else begin
         inject_q <= inject_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode state machine
   always_comb begin
      md_d   = md_q;
      hold_d = 13'h0000;
      case (md_q)
         MD_POWER_DOWN: begin
            if (pin.por_ok) begin
               md_d = MD_SHUTDOWN;
            end
         end
         MD_SHUTDOWN: begin
            if (pin.en_ok) begin
               md_d = pin.low_power_request_n ? MD_ACTIVE : MD_WAIT_LP;
            end
         end
         MD_WAIT_LP: begin
            hold_d = hold_q + 13'h0001;
            if (pin.low_power_request_n) begin
               md_d = MD_ACTIVE;
            end else if (hold_q == 13'(LPM_HOLD - 1)) begin
               md_d = MD_LOW_POWER;
            end
         end
         MD_LOW_POWER: begin
            if (pin.low_power_request_n) begin
               md_d = MD_ACTIVE;
            end else if (out_q.bypass_gate && pin.bypass_gate_enhanced &&
                         pin.load_wakeup_compare) begin
               md_d = MD_WAKEUP;
            end
         end
         MD_WAKEUP: begin
            // wakeup holds until the request pin confirms it
            if (pin.low_power_request_n) begin
               md_d = MD_ACTIVE;
            end
         end
         MD_ACTIVE: begin
            // controller is expected to hold the gate command 10us longer
            if (!pin.low_power_request_n) begin
               md_d = MD_LOW_POWER;
            end
         end
         default: md_d = MD_POWER_DOWN;
      endcase
      // supply loss beats enable loss
      if (!pin.por_ok) begin
         md_d = MD_POWER_DOWN;
      end else if (!pin.en_ok && md_q != MD_POWER_DOWN) begin
         md_d = MD_SHUTDOWN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         md_q   <= MD_POWER_DOWN;
         hold_q <= 13'h0000;
      end else begin
         md_q   <= md_d;
         hold_q <= hold_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gate drive and flag outputs, all registered
   logic main_on;
   logic uv_fault;

   always_comb begin
      main_on = 1'b0;
      case (md_q)
         MD_ACTIVE: main_on = pin.main_gate_command;
         MD_WAKEUP: main_on = 1'b1;
         default:   main_on = 1'b0;
      endcase
      // undervoltage overrides every mode
      if (sc_fault || uv) begin
         main_on = 1'b0;
      end
      uv_fault = uv && (md_q == MD_LOW_POWER || prot_on);
      out_d.main_gate_pullup   = main_on;
      out_d.main_gate_pulldown = !main_on;
      out_d.bypass_gate        = (md_q == MD_LOW_POWER) && !uv;
      out_d.wake_n             = !prot_on;
      out_d.fault_flag_n       = !(sc_fault || uv_fault);
      out_d.charge_pump_en     = (md_q != MD_POWER_DOWN) &&
                                 (md_q != MD_SHUTDOWN);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         out_q <= '{
            main_gate_pullup:   1'b0,
            main_gate_pulldown: 1'b1,
            bypass_gate:        1'b0,
            wake_n:             1'b1,
            fault_flag_n:       1'b1,
            charge_pump_en:     1'b0
         };
      end else begin
         out_q <= out_d;
      end
   end

   assign main_gate_pullup_o   = out_q.main_gate_pullup;
   assign main_gate_pulldown_o = out_q.main_gate_pulldown;
   assign bypass_gate_o        = out_q.bypass_gate;
   assign wake_n_o             = out_q.wake_n;
   assign fault_flag_n_o       = out_q.fault_flag_n;
   assign charge_pump_en_o     = out_q.charge_pump_en;

endmodule : hsd_ctrl

// ===== rtl/hsd_pkg.sv
// shared constants, types and register map of the high-side driver control core
package hsd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned LPM_HOLD_US      = 500;
   localparam int unsigned LPM_HOLD_CYC     = (LPM_HOLD_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
   localparam int unsigned FAST_RESP_US     = 10;
   localparam int unsigned FAST_RESP_CYC    = (FAST_RESP_US * 1000) / CLK_PERIOD_NS;
   // later retry intervals must stay below the fast response time
   localparam int unsigned FAST_RETRY_CYC   = FAST_RESP_CYC / 2;
   localparam int unsigned RETRY_CYCLES     = 32;

   ////////////////////////////////////////////////////////////////////////////
   // timer currents in units of 0.1 uA, used as counter steps
   localparam int unsigned TMR_W            = 24;
   localparam logic [TMR_W-1:0] I_CHG_STEP  = 24'h000320;
   localparam logic [TMR_W-1:0] I_RDN_STEP  = 24'h000019;
   localparam logic [TMR_W-1:0] I_RUP_STEP  = 24'h000016;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [3:0] ADDR_CTRL         = 4'h0;
   localparam logic [3:0] ADDR_TRIP         = 4'h4;
   localparam logic [3:0] ADDR_LOW          = 4'h8;
   localparam logic [3:0] ADDR_STAT         = 4'hC;
   localparam int unsigned CTRL_LATCH_BIT   = 0;
   localparam int unsigned CTRL_NOCAP_BIT   = 1;
   localparam logic [1:0]       CTRL_RST    = 2'h0;
   localparam logic [TMR_W-1:0] TRIP_RST    = 24'h004E20;
   localparam logic [TMR_W-1:0] LOW_RST     = 24'h0007D0;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      MD_POWER_DOWN = 3'b000,
      MD_SHUTDOWN   = 3'b001,
      MD_WAIT_LP    = 3'b010,
      MD_LOW_POWER  = 3'b011,
      MD_WAKEUP     = 3'b100,
      MD_ACTIVE     = 3'b101
   } hsd_mode_e;

   typedef struct packed {
      logic por_ok;
      logic en_ok;
      logic low_power_request_n;
      logic main_gate_command;
      logic short_detect_selftest;
      logic short_circuit_compare;
      logic load_wakeup_compare;
      logic main_gate_enhanced;
      logic bypass_gate_enhanced;
      logic charge_pump_uv;
      logic input_uv;
   } hsd_pins_s;

   typedef struct packed {
      logic main_gate_pullup;
      logic main_gate_pulldown;
      logic bypass_gate;
      logic wake_n;
      logic fault_flag_n;
      logic charge_pump_en;
   } hsd_gates_s;

endpackage : hsd_pkg

// ===== rtl/hsd_sync.sv
// two-flop synchroniser bank for pin and comparator inputs
`timescale 1ns/1ps
module hsd_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second stage
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            meta_q[b] <= 1'b0;
            sync_q[b] <= 1'b0;
         end else begin
            meta_q[b] <= async_i[b];
            sync_q[b] <= meta_q[b];
         end
      end
   end

   assign sync_o = sync_q;
endmodule : hsd_sync

// ===== rtl/hsd_fault_timer.sv
// short-circuit delay, auto-retry and latch-off timer model
`timescale 1ns/1ps
module hsd_fault_timer
   import hsd_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             clear_i,
   input  wire logic             oc_i,
   input  wire logic             nocap_i,
   input  wire logic             latch_off_i,
   input  wire logic [TMR_W-1:0] trip_lvl_i,
   input  wire logic [TMR_W-1:0] low_lvl_i,
   output logic                  fault_o,
   output logic                  latched_o
);
   typedef enum logic [2:0] {
      TM_IDLE     = 3'b000,
      TM_CHARGE   = 3'b001,
      TM_RETRY_DN = 3'b010,
      TM_RETRY_UP = 3'b011,
      TM_LATCH    = 3'b100,
      TM_FAST     = 3'b101
   } hsd_tmr_e;

   hsd_tmr_e         st_q, st_d;
   logic [TMR_W-1:0] lvl_q, lvl_d;
   logic [5:0]       n_q, n_d;
   logic [7:0]       cyc_q, cyc_d;
   logic             used_q, used_d;
   logic [TMR_W:0]   up_chg, up_rup, low_dn;

   assign up_chg = {1'b0, lvl_q} + {1'b0, I_CHG_STEP};
   assign up_rup = {1'b0, lvl_q} + {1'b0, I_RUP_STEP};
   assign low_dn = {1'b0, low_lvl_i} + {1'b0, I_RDN_STEP};

   always_comb begin
      st_d   = st_q;
      lvl_d  = lvl_q;
      n_d    = n_q;
      cyc_d  = cyc_q;
      used_d = used_q;
      case (st_q)
         TM_IDLE: begin
            if (oc_i) begin
               if (nocap_i) begin
                  st_d = latch_off_i ? TM_LATCH : TM_FAST;
                  cyc_d = 8'h00;
               end else begin
                  st_d = TM_CHARGE;
               end
            end
         end
         TM_CHARGE: begin
            if (!oc_i) begin
               st_d  = TM_IDLE;
               lvl_d = '0;
            end else if (up_chg >= {1'b0, trip_lvl_i}) begin
               lvl_d = trip_lvl_i;
               n_d   = 6'h00;
               cyc_d = 8'h00;
               if (latch_off_i) begin
                  st_d = TM_LATCH;
               end else if (used_q) begin
                  st_d = TM_FAST;
               end else begin
                  st_d = TM_RETRY_DN;
               end
            end else begin
               lvl_d = up_chg[TMR_W-1:0];
            end
         end
         TM_RETRY_DN: begin
            if ({1'b0, lvl_q} <= low_dn) begin
               lvl_d = low_lvl_i;
               st_d  = TM_RETRY_UP;
            end else begin
               lvl_d = lvl_q - I_RDN_STEP;
            end
         end
         TM_RETRY_UP: begin
            if (up_rup >= {1'b0, trip_lvl_i}) begin
               lvl_d = trip_lvl_i;
               n_d   = n_q + 6'h01;
               if (n_q == 6'(RETRY_CYCLES - 1)) begin
                  st_d   = TM_IDLE;
                  lvl_d  = '0;
                  used_d = 1'b1;
               end else begin
                  st_d = TM_RETRY_DN;
               end
            end else begin
               lvl_d = up_rup[TMR_W-1:0];
            end
         end
         TM_FAST: begin
            cyc_d = cyc_q + 8'h01;
            if (cyc_q == 8'(FAST_RETRY_CYC - 1)) begin
               st_d  = TM_IDLE;
               lvl_d = '0;
            end
         end
         TM_LATCH: st_d = TM_LATCH;
         default:  st_d = TM_IDLE;
      endcase
      if (clear_i) begin
         st_d   = TM_IDLE;
         lvl_d  = '0;
         n_d    = 6'h00;
         used_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_q   <= TM_IDLE;
         lvl_q  <= '0;
         n_q    <= 6'h00;
         cyc_q  <= 8'h00;
         used_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         lvl_q  <= lvl_d;
         n_q    <= n_d;
         cyc_q  <= cyc_d;
         used_q <= used_d;
      end
   end

   assign fault_o   = (st_q == TM_RETRY_DN) || (st_q == TM_RETRY_UP) ||
                      (st_q == TM_FAST) || (st_q == TM_LATCH);
   assign latched_o = (st_q == TM_LATCH);
endmodule : hsd_fault_timer

// ===== verification/hsd_monitor.sv
// assertion checker on the pins of the driver control core
`timescale 1ns/1ps
module hsd_monitor (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic supply_por_ok_i,
   input  wire logic enable_undervoltage_input_i,
   input  wire logic low_power_request_n_i,
   input  wire logic main_gate_command_i,
   input  wire logic input_uv_falling_level_i,
   input  wire logic main_gate_pullup_o,
   input  wire logic main_gate_pulldown_o,
   input  wire logic bypass_gate_o,
   input  wire logic wake_n_o,
   input  wire logic fault_flag_n_o,
   input  wire logic charge_pump_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////////
   // pin changes need sync, mode and output edges, hence the six-cycle antecedents and the eight-cycle one for wake
   pwr_off_a: assert property (!supply_por_ok_i [*6] |=> !main_gate_pullup_o && !bypass_gate_o
      && !charge_pump_en_o) else $error("gate on without supply");
   shut_off_a: assert property ((supply_por_ok_i && !enable_undervoltage_input_i) [*6] |=>
      !main_gate_pullup_o && !bypass_gate_o && fault_flag_n_o) else $error("shutdown gate");
   gate_excl_a: assert property (!(main_gate_pullup_o && bypass_gate_o))
      else $error("both gates on");
   pd_inv_a: assert property (main_gate_pulldown_o == !main_gate_pullup_o)
      else $error("pull pair clash");
   fault_gate_a: assert property ($fell(fault_flag_n_o) |-> !main_gate_pullup_o)
      else $error("fault with gate on");
   uv_off_a: assert property (input_uv_falling_level_i [*6] |=> !main_gate_pullup_o
      && !bypass_gate_o) else $error("gate on in undervoltage");
   cmd_follow_a: assert property ((!main_gate_command_i && low_power_request_n_i) [*6] |=>
      !main_gate_pullup_o) else $error("gate ignores command");
   wake_act_a: assert property ((supply_por_ok_i && enable_undervoltage_input_i
      && low_power_request_n_i && !input_uv_falling_level_i) [*8] |=> !wake_n_o)
      else $error("wake not asserted");
endmodule : hsd_monitor

bind hsd_ctrl hsd_monitor i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .supply_por_ok_i(supply_por_ok_i), .enable_undervoltage_input_i(enable_undervoltage_input_i),
   .low_power_request_n_i(low_power_request_n_i), .main_gate_command_i(main_gate_command_i),
   .input_uv_falling_level_i(input_uv_falling_level_i), .main_gate_pullup_o(main_gate_pullup_o),
   .main_gate_pulldown_o(main_gate_pulldown_o), .bypass_gate_o(bypass_gate_o),
   .wake_n_o(wake_n_o), .fault_flag_n_o(fault_flag_n_o), .charge_pump_en_o(charge_pump_en_o));

// ===== verification/hsd_fet_model.sv
// external fets and current sense facing the gate outputs
`timescale 1ns/1ps
module hsd_fet_model #(
   parameter int unsigned ENH = 3
) (
   input  wire logic clk_i,
   input  wire logic main_gate_pullup_i,
   input  wire logic bypass_gate_i,
   input  wire logic short_req_i,
   input  wire logic load_req_i,
   output logic      main_enh_o,
   output logic      bypass_enh_o,
   output logic      short_cmp_o,
   output logic      load_cmp_o
);
   logic [3:0] m_q = 4'h0;
   logic [3:0] b_q = 4'h0;
   // gates charge slowly, the strong sink empties them at once
   always @(posedge clk_i) begin
      m_q <= !main_gate_pullup_i ? 4'h0 : (m_q < ENH) ? m_q + 4'h1 : m_q;
      b_q <= !bypass_gate_i ? 4'h0 : (b_q < ENH) ? b_q + 4'h1 : b_q;
   end
   assign main_enh_o = (m_q == ENH[3:0]);
   assign bypass_enh_o = (b_q == ENH[3:0]);
   // current flows only through a conducting path
   assign short_cmp_o = short_req_i && main_gate_pullup_i;
   assign load_cmp_o = (load_req_i || short_req_i) && bypass_gate_i;
endmodule : hsd_fet_model

// ===== verification/hsd_ctrl_bench.sv
// self-checking bench for the driver control core
`timescale 1ns/1ps
module hsd_ctrl_bench;
   import hsd_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        por = 1'b0, en = 1'b0, req_n = 1'b0, cmd = 1'b0, tst = 1'b0;
   logic        cpuv = 1'b0, uv = 1'b0, shrt = 1'b0, load = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0, rdat, q;
   logic        sc, lw, me, be, pu, pd, by, wk, fl, cp, wq;
   logic [7:0]  seed = 8'h2E;
   int          bad_count = 0, num_checks = 0, cyc = 0;
   initial forever #50 clk_i = ~clk_i;
   hsd_ctrl #(.LPM_HOLD(20)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .supply_por_ok_i(por),
      .enable_undervoltage_input_i(en), .low_power_request_n_i(req_n),
      .main_gate_command_i(cmd), .short_detect_selftest_i(tst), .short_circuit_compare_i(sc),
      .load_wakeup_compare_i(lw), .main_gate_enhanced_level_i(me),
      .bypass_gate_enhanced_level_i(be), .charge_pump_uv_level_i(cpuv),
      .input_uv_falling_level_i(uv), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wq), .main_gate_pullup_o(pu), .main_gate_pulldown_o(pd),
      .bypass_gate_o(by), .wake_n_o(wk), .fault_flag_n_o(fl), .charge_pump_en_o(cp));
   hsd_fet_model i_fet (.clk_i(clk_i), .main_gate_pullup_i(pu), .bypass_gate_i(by),
      .short_req_i(shrt), .load_req_i(load), .main_enh_o(me), .bypass_enh_o(be),
      .short_cmp_o(sc), .load_cmp_o(lw));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic st(input int n);
      repeat (n) @(posedge clk_i);
   endtask : st
   // no cycle count assumed: wait for waitrequest low, bounded by the run timeout
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk_i); while (wq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic gt(input logic [3:0] e);
      chk({28'h0, pu, by, wk, fl}, {28'h0, e});
   endtask : gt
   task automatic wf(input logic v, input int m);
      int n;
      n = 0;
      while (fl !== v && n < m) begin
         @(posedge clk_i);
         n++;
      end
      chk({31'h0, fl}, {31'h0, v});
   endtask : wf
   task automatic clr;
      cmd <= 1'b0;
      st(8);
      cmd <= 1'b1;
      st(12);
   endtask : clr
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      st(6);
      rst_n_i <= 1'b1;
      bus(0, ADDR_TRIP, 0);
      chk(q, {8'h0, TRIP_RST});
      bus(0, ADDR_LOW, 0);
      chk(q, {8'h0, LOW_RST});
      bus(1, 4'h2, 32'hFFFFFFFF);
      bus(0, 4'h2, 0);
      chk(q, 32'h0);
      gt(4'b0011);
      por <= 1'b1;
      st(8);
      gt(4'b0011);
      en <= 1'b1;
      req_n <= 1'b1;
      cmd <= 1'b1;
      st(10);
      gt(4'b1001);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         cmd <= seed[0];
         st(8);
         chk({31'h0, pu}, {31'h0, seed[0]});
      end
      cmd <= 1'b1;
      st(10);
      $display("test modes done");
      shrt <= 1'b1;
      st(15);
      shrt <= 1'b0;
      st(10);
      shrt <= 1'b1;
      st(15);
      gt(4'b1001);
      wf(1'b0, 30);
      shrt <= 1'b0;
      bus(1, ADDR_TRIP, 32'h3E8);
      bus(1, ADDR_LOW, 32'h384);
      st(30);
      chk({31'h0, fl}, 32'h0);
      wf(1'b1, 2000);
      st(8);
      gt(4'b1001);
      shrt <= 1'b1;
      wf(1'b0, 30);
      shrt <= 1'b0;
      wf(1'b1, 99);
      bus(1, ADDR_CTRL, 32'h3);
      shrt <= 1'b1;
      wf(1'b0, 100);
      shrt <= 1'b0;
      st(600);
      gt(4'b0000);
      clr();
      gt(4'b1001);
      tst <= 1'b1;
      wf(1'b0, 100);
      gt(4'b0000);
      tst <= 1'b0;
      clr();
      $display("test short done");
      uv <= 1'b1;
      st(8);
      gt(4'b0000);
      uv <= 1'b0;
      en <= 1'b0;
      st(8);
      gt(4'b0011);
      en <= 1'b1;
      req_n <= 1'b0;
      st(10);
      chk({31'h0, by}, 32'h0);
      st(20);
      gt(4'b0111);
      load <= 1'b1;
      st(12);
      gt(4'b1001);
      bus(0, ADDR_STAT, 0);
      chk({29'h0, q[2:0]}, 32'h4);
      req_n <= 1'b1;
      load <= 1'b0;
      st(8);
      bus(0, ADDR_STAT, 0);
      chk({29'h0, q[2:0]}, 32'h5);
      req_n <= 1'b0;
      st(10);
      gt(4'b0111);
      cpuv <= 1'b1;
      st(8);
      gt(4'b0010);
      cpuv <= 1'b0;
      por <= 1'b0;
      st(8);
      gt(4'b0011);
      chk({31'h0, cp}, 32'h0);
      $display("test low power done");
      print_verdict();
   end
endmodule : hsd_ctrl_bench
